// ### rtl/seq_pkg.sv
package seq_pkg;

   // ****************************************************************
   // widths and timing
   // ****************************************************************
   localparam int DATA_W = 8;
   localparam int PADDR_W = 11;
   localparam int DADDR_W = 7;
   localparam int OP_W = 5;
   localparam int PHASES_PER_ICYCLE = 4;
   localparam logic [1:0] LAST_PHASE = 2'h3;
   localparam logic [PADDR_W-1:0] PC_RESET = 11'h000;
   localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
   localparam logic [DADDR_W-1:0] PCL_ADDR = 7'h06;
   localparam logic [DATA_W-1:0] MAX_VALUE = 8'hFF;
   localparam int STACK_DEPTH = 4;

   // ****************************************************************
   // operation classes
   // ****************************************************************
   typedef enum logic [OP_W-1:0] {
      nop_op,
      mov_to_acc_op,
      mov_to_mem_op,
      mov_imm_op,
      add_op,
      add_imm_op,
      sub_op,
      sub_imm_op,
      and_op,
      or_op,
      xor_op,
      complement_op,
      complement_to_acc_op,
      increment_op,
      increment_to_accumulator_op,
      decrement_op,
      decrement_to_accumulator_op,
      rotate_right_op,
      rotate_left_op,
      rotate_right_through_carry_op,
      rotate_left_through_carry_op,
      bit_set_op,
      bit_clear_op,
      skip_zero_op,
      skip_bit_zero_op,
      skip_bit_set_op,
      unconditional_jump_op,
      call_op,
      return_op,
      return_from_interrupt_op,
      table_read_op
   } op_t;

endpackage : seq_pkg

// ### rtl/return_stack.sv
`timescale 1ns/1ps
module return_stack #(
   parameter int DEPTH = seq_pkg::STACK_DEPTH,
   parameter int WIDTH = seq_pkg::PADDR_W
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic push,
   input wire logic pop,
   input wire logic [WIDTH-1:0] push_data,
   output logic [WIDTH-1:0] top_data
);
   import seq_pkg::*;

   localparam int PTR_W = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] ptr_reg;
   logic [PTR_W-1:0] ptr_next;
   logic [PTR_W-1:0] rd_ptr;

   assign ptr_next = push ? ptr_reg + 1'b1 : (pop ? ptr_reg - 1'b1 : ptr_reg);
   assign rd_ptr = ptr_reg - 1'b1;

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         ptr_reg <= '0;
      end else begin
         ptr_reg <= ptr_next;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[ptr_reg] <= push_data;
      end
   end

   // registered read of the current top entry
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         top_data <= '0;
      end else if (push) begin
         top_data <= push_data;
      end else if (pop) begin
         top_data <= mem[rd_ptr - 1'b1];
      end else begin
         top_data <= mem[rd_ptr];
      end
   end

endmodule : return_stack

// ### rtl/instruction_cycle_sequencer.sv
`timescale 1ns/1ps
// Contract
// - one instruction cycle is exactly four system clocks
// - instructions otherwise complete in one instruction cycle
// - jump, call and table read take two instruction cycles
// - return and return from interrupt take two instruction cycles
// - writing program counter low byte jumps and costs one extra cycle
// - skip costs one cycle, two when the next instruction is skipped
// - satisfied test discards next instruction, resumes after it
// - call saves next address for return; plain jump saves nothing
// - move register to acc, acc to register, immediate to acc
// - add flags carry above 255, subtract flags borrow below zero
// - increment and decrement by one into acc or memory
// - logic operations set zero on zero result, clear otherwise
// - two-operand operations take one operand from the accumulator
// - rotate by one; through-carry variants exchange bit with carry
// - bit set and clear read, modify one bit, write back
// - table read fetches program memory constant into the table_data register
module instruction_cycle_sequencer (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic instr_valid,
   input wire seq_pkg::op_t instr_op,
   input wire logic [seq_pkg::DADDR_W-1:0] instr_mem_addr,
   input wire logic [seq_pkg::DATA_W-1:0] instr_imm,
   input wire logic [2:0] instr_bit,
   input wire logic [seq_pkg::PADDR_W-1:0] instr_target,
   input wire logic [seq_pkg::DATA_W-1:0] mem_rdata,
   input wire logic [seq_pkg::DATA_W-1:0] table_rdata,
   output logic [seq_pkg::PADDR_W-1:0] pc,
   output logic fetch_strobe,
   output logic flush,
   output logic instr_done,
   output logic [seq_pkg::DADDR_W-1:0] mem_addr,
   output logic mem_we,
   output logic [seq_pkg::DATA_W-1:0] mem_wdata,
   output logic [seq_pkg::PADDR_W-1:0] table_addr,
   output logic [seq_pkg::DATA_W-1:0] table_data,
   output logic [seq_pkg::DATA_W-1:0] acc,
   output logic zero_flag,
   output logic carry_flag,
   output logic irq_enable
);
   import seq_pkg::*;

   // ****************************************************************
   // state
   // ****************************************************************
   typedef enum {exec_st, extra_st} state_t;

   state_t state_reg;
   state_t state_next;
   logic [1:0] phase_reg;
   logic [PADDR_W-1:0] pc_next;
   op_t op_reg;
   logic [DADDR_W-1:0] addr_reg;
   logic [DATA_W-1:0] imm_reg;
   logic [2:0] bit_reg;
   logic [PADDR_W-1:0] target_reg;
   logic [DATA_W-1:0] acc_next;
   logic [DATA_W-1:0] wdata_next;
   logic [PADDR_W-1:0] redirect_pc;
   logic table_pend_reg;

   // ****************************************************************
   // decode and datapath
   // ****************************************************************
   wire last_phase = (phase_reg == LAST_PHASE);
   wire issue = (state_reg == exec_st) && (phase_reg == 2'h0) && instr_valid;
   wire execute = (state_reg == exec_st) && last_phase;
   wire [DATA_W-1:0] operand = mem_rdata;
   wire [DATA_W-1:0] bit_mask = 8'h01 << bit_reg;
   wire [DATA_W:0] sum = {1'b0, acc} + {1'b0, operand};
   wire [DATA_W:0] sum_imm = {1'b0, acc} + {1'b0, imm_reg};
   wire [DATA_W:0] diff = {1'b0, acc} - {1'b0, operand};
   wire [DATA_W:0] diff_imm = {1'b0, acc} - {1'b0, imm_reg};
   wire [DATA_W-1:0] and_res = acc & operand;
   wire [DATA_W-1:0] or_res = acc | operand;
   wire [DATA_W-1:0] xor_res = acc ^ operand;
   wire [DATA_W-1:0] cpl_res = ~operand;
   wire [DATA_W-1:0] inc_res = operand + 8'h01;
   wire [DATA_W-1:0] dec_res = operand - 8'h01;
   wire [DATA_W-1:0] rr_res = {operand[0], operand[DATA_W-1:1]};
   wire [DATA_W-1:0] rl_res = {operand[DATA_W-2:0], operand[DATA_W-1]};
   wire [DATA_W-1:0] rrc_res = {carry_flag, operand[DATA_W-1:1]};
   wire [DATA_W-1:0] rlc_res = {operand[DATA_W-2:0], carry_flag};
   wire [DATA_W-1:0] set_res = operand | bit_mask;
   wire [DATA_W-1:0] clr_res = operand & ~bit_mask;
   wire is_branch = (op_reg == unconditional_jump_op) || (op_reg == call_op);
   wire is_return = (op_reg == return_op) ||
      (op_reg == return_from_interrupt_op);
   wire skip_taken = ((op_reg == skip_zero_op) && (operand == 8'h00)) ||
      ((op_reg == skip_bit_zero_op) && !operand[bit_reg]) ||
      ((op_reg == skip_bit_set_op) && operand[bit_reg]);
   wire mem_write_op = (op_reg == mov_to_mem_op) ||
      (op_reg == complement_op) || (op_reg == increment_op) ||
      (op_reg == decrement_op) || (op_reg == rotate_right_op) ||
      (op_reg == rotate_left_op) ||
      (op_reg == rotate_right_through_carry_op) ||
      (op_reg == rotate_left_through_carry_op) ||
      (op_reg == bit_set_op) || (op_reg == bit_clear_op);
   wire pcl_write = mem_write_op && (addr_reg == PCL_ADDR);
   wire two_cycle = is_branch || is_return || skip_taken || pcl_write ||
      (op_reg == table_read_op);
   wire push = execute && (op_reg == call_op);
   wire pop = execute && is_return;
   wire [PADDR_W-1:0] stack_top;
   wire [PADDR_W-1:0] seq_pc = pc + 11'h001;

   always_comb begin
      wdata_next = operand;
      acc_next = acc;
      unique case (op_reg)
         mov_to_acc_op: acc_next = operand;
         mov_to_mem_op: wdata_next = acc;
         mov_imm_op: acc_next = imm_reg;
         add_op: acc_next = sum[DATA_W-1:0];
         add_imm_op: acc_next = sum_imm[DATA_W-1:0];
         sub_op: acc_next = diff[DATA_W-1:0];
         sub_imm_op: acc_next = diff_imm[DATA_W-1:0];
         and_op: acc_next = and_res;
         or_op: acc_next = or_res;
         xor_op: acc_next = xor_res;
         complement_op: wdata_next = cpl_res;
         complement_to_acc_op: acc_next = cpl_res;
         increment_op: wdata_next = inc_res;
         increment_to_accumulator_op: acc_next = inc_res;
         decrement_op: wdata_next = dec_res;
         decrement_to_accumulator_op: acc_next = dec_res;
         rotate_right_op: wdata_next = rr_res;
         rotate_left_op: wdata_next = rl_res;
         rotate_right_through_carry_op: wdata_next = rrc_res;
         rotate_left_through_carry_op: wdata_next = rlc_res;
         bit_set_op: wdata_next = set_res;
         bit_clear_op: wdata_next = clr_res;
         default: acc_next = acc;
      endcase
   end

   // pcl write replaces only the low byte of the counter
   assign redirect_pc = is_branch ? target_reg :
      is_return ? stack_top :
      pcl_write ? {pc[PADDR_W-1:DATA_W], wdata_next} :
      skip_taken ? pc + 11'h002 : seq_pc;
   assign pc_next = execute ? redirect_pc : pc;
   assign state_next = (execute && two_cycle) ? extra_st :
      ((state_reg == extra_st) && last_phase) ? exec_st : state_reg;

   // ****************************************************************
   // sequencing registers
   // ****************************************************************
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         phase_reg <= 2'h0;
         state_reg <= exec_st;
      end else begin
         phase_reg <= phase_reg + 2'h1;
         state_reg <= state_next;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         op_reg <= nop_op;
         addr_reg <= '0;
         imm_reg <= '0;
         bit_reg <= '0;
         target_reg <= PC_RESET;
      end else if (issue) begin
         op_reg <= instr_op;
         addr_reg <= instr_mem_addr;
         imm_reg <= instr_imm;
         bit_reg <= instr_bit;
         target_reg <= instr_target;
      end else if (execute) begin
         op_reg <= nop_op;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         pc <= PC_RESET;
         fetch_strobe <= 1'b0;
         flush <= 1'b0;
         instr_done <= 1'b0;
      end else begin
         pc <= pc_next;
         fetch_strobe <= last_phase;
         flush <= execute && two_cycle;
         instr_done <= (execute && !two_cycle) ||
            ((state_reg == extra_st) && last_phase);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         acc <= ACC_RESET;
         zero_flag <= 1'b0;
         carry_flag <= 1'b0;
         irq_enable <= 1'b0;
         mem_addr <= '0;
         mem_we <= 1'b0;
         mem_wdata <= '0;
         table_addr <= '0;
         table_data <= '0;
         table_pend_reg <= 1'b0;
      end else begin
         mem_addr <= issue ? instr_mem_addr : mem_addr;
         mem_we <= execute && mem_write_op;
         mem_wdata <= execute ? wdata_next : mem_wdata;
         if (execute) begin
            acc <= acc_next;
         end
         if (execute && (op_reg inside {and_op, or_op, xor_op,
               complement_op, complement_to_acc_op})) begin
            zero_flag <= (op_reg inside {complement_op,
               complement_to_acc_op}) ? (cpl_res == 8'h00) :
               (acc_next == 8'h00);
         end
         if (execute && (op_reg inside {add_op, add_imm_op})) begin
            carry_flag <= (op_reg == add_op) ? sum[DATA_W] :
               sum_imm[DATA_W];
         end else if (execute && (op_reg inside {sub_op, sub_imm_op})) begin
            carry_flag <= (op_reg == sub_op) ? diff[DATA_W] :
               diff_imm[DATA_W];
         end else if (execute && (op_reg inside
               {rotate_right_through_carry_op,
               rotate_right_op})) begin
            if (op_reg == rotate_right_through_carry_op) begin
               carry_flag <= operand[0];
            end
         end else if (execute &&
               (op_reg == rotate_left_through_carry_op)) begin
            carry_flag <= operand[DATA_W-1];
         end
         if (execute && (op_reg == return_from_interrupt_op)) begin
            irq_enable <= 1'b1;
         end
         if (execute && (op_reg == table_read_op)) begin
            table_addr <= target_reg;
         end
         if (execute) begin
            table_pend_reg <= (op_reg == table_read_op);
         end
         if ((state_reg == extra_st) && last_phase && table_pend_reg) begin
            table_data <= table_rdata;
         end
      end
   end

   return_stack #(
      .DEPTH(STACK_DEPTH),
      .WIDTH(PADDR_W)
   ) u_stack (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .push(push),
      .pop(pop),
      .push_data(seq_pc),
      .top_data(stack_top)
   );

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   sequence two_cycle_seq;
      execute && two_cycle ##1 flush;
   endsequence

   phase_wrap_a: assert property (last_phase |=> phase_reg == 2'h0)
      else $error("phase did not wrap after four clocks");
   single_done_a: assert property (
      execute && !two_cycle |=> instr_done)
      else $error("single cycle instruction not done");
   branch_extra_a: assert property (
      two_cycle_seq |-> ##4 instr_done)
      else $error("two cycle instruction done late");
   return_pc_a: assert property (
      execute && is_return |=> pc == $past(stack_top))
      else $error("return went to wrong address");
   pcl_jump_a: assert property (execute && pcl_write |=> flush)
      else $error("pcl write did not jump");
   skip_pc_a: assert property (
      execute && skip_taken |=> pc == $past(pc) + 11'h002)
      else $error("skip did not discard next");
   skip_time_a: assert property (
      execute && skip_taken |=> !instr_done[*4])
      else $error("skip finished in one cycle");
   no_skip_a: assert property (
      execute && !two_cycle |=> pc == $past(pc) + 11'h001)
      else $error("sequential fetch wrong");
   add_carry_a: assert property (
      execute && op_reg == add_op |=> carry_flag == $past(sum[DATA_W]))
      else $error("carry wrong after add");
   logic_zero_a: assert property (
      execute && op_reg == and_op |=> zero_flag == (acc == 8'h00))
      else $error("zero flag wrong after and");
   bit_set_a: assert property (
      execute && op_reg == bit_set_op
      |=> mem_we && mem_wdata == ($past(operand) | $past(bit_mask)))
      else $error("bit set changed other bits");
   return_from_interrupt_op_irq_a: assert property (
      execute && op_reg == return_from_interrupt_op |=> irq_enable)
      else $error("return from interrupt left interrupts off");
   table_load_a: assert property (
      (state_reg == extra_st) && last_phase && table_pend_reg
      |=> table_data == $past(table_rdata))
      else $error("table data not loaded");

endmodule : instruction_cycle_sequencer

// ### verif/mem_model.sv
`timescale 1ns/1ps
module mem_model (
   input wire logic ref_clk,
   input wire logic [seq_pkg::DADDR_W-1:0] mem_addr,
   input wire logic mem_we,
   input wire logic [seq_pkg::DATA_W-1:0] mem_wdata,
   input wire logic [seq_pkg::PADDR_W-1:0] table_addr,
   output logic [seq_pkg::DATA_W-1:0] mem_rdata,
   output logic [seq_pkg::DATA_W-1:0] table_rdata
);
   import seq_pkg::*;
   // ********************
   // data memory
   // ********************
   logic [DATA_W-1:0] dmem [0:127];
   initial begin
      for (int i = 0; i < 128; i++) begin
         dmem[i] = 8'hC3;
      end
   end
   always @(posedge ref_clk) begin
      if (mem_we) begin
         dmem[mem_addr] <= mem_wdata;
      end
   end
   assign mem_rdata = dmem[mem_addr];
   // ********************
   // constant table
   // ********************
   // contents differ between addresses that share their top three bits, so a wrong low byte shows
   assign table_rdata = table_addr[7:0] ^ {table_addr[10:8], 5'h15};
endmodule : mem_model

// ### verif/tb_instruction_cycle_sequencer.sv
`timescale 1ns/1ps
module tb_instruction_cycle_sequencer;
   import seq_pkg::*;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic instr_valid = 1'b0;
   op_t instr_op = nop_op;
   logic [DADDR_W-1:0] instr_mem_addr = 7'h00;
   logic [DATA_W-1:0] instr_imm = 8'h00;
   logic [2:0] instr_bit = 3'h0;
   logic [PADDR_W-1:0] instr_target = 11'h000;
   logic [DATA_W-1:0] mem_rdata, table_rdata, mem_wdata, table_data, acc;
   logic [PADDR_W-1:0] pc, table_addr, pc0, pc1;
   logic [DADDR_W-1:0] mem_addr;
   logic fetch_strobe, flush, instr_done, mem_we, zero_flag, carry_flag;
   logic irq_enable, saw_flush;
   int fails = 0;
   int checks_done = 0;

   always #2 ref_clk = ~ref_clk;

   instruction_cycle_sequencer i_dut (.ref_clk(ref_clk), .resetn(resetn),
      .instr_valid(instr_valid), .instr_op(instr_op),
      .instr_mem_addr(instr_mem_addr), .instr_imm(instr_imm),
      .instr_bit(instr_bit), .instr_target(instr_target),
      .mem_rdata(mem_rdata), .table_rdata(table_rdata), .pc(pc),
      .fetch_strobe(fetch_strobe), .flush(flush), .instr_done(instr_done),
      .mem_addr(mem_addr), .mem_we(mem_we), .mem_wdata(mem_wdata),
      .table_addr(table_addr), .table_data(table_data), .acc(acc),
      .zero_flag(zero_flag), .carry_flag(carry_flag),
      .irq_enable(irq_enable));

   mem_model i_mem (.ref_clk(ref_clk), .mem_addr(mem_addr), .mem_we(mem_we),
      .mem_wdata(mem_wdata), .table_addr(table_addr),
      .mem_rdata(mem_rdata), .table_rdata(table_rdata));

   // ********************
   // shared tasks
   // ********************
   task automatic tally_and_finish();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic poke(logic [6:0] a, logic [7:0] v);
      i_mem.dmem[a] = v;
   endtask : poke

   // a write launched at the done edge lands at the following edge
   function automatic logic [7:0] mem_at(logic [6:0] a);
      return (mem_we === 1'b1 && mem_addr == a) ? mem_wdata : i_mem.dmem[a];
   endfunction : mem_at

   // entered just after the edge before a phase 0 edge; returns just after
   // the done edge, which again precedes a phase 0 edge
   task automatic issue(op_t op, logic [6:0] a, logic [7:0] v, int ncyc);
      int n;
      int nf;
      n = 1;
      nf = 0;
      saw_flush = 1'b0;
      pc0 = pc;
      instr_op <= op;
      instr_mem_addr <= a;
      instr_imm <= v;
      instr_valid <= 1'b1;
      @(posedge ref_clk);
      instr_valid <= 1'b0;
      do begin
         @(posedge ref_clk);
         #1;
         n++;
         if (fetch_strobe === 1'b1) begin
            nf++;
         end
         saw_flush = saw_flush | flush;
      end while (instr_done !== 1'b1 && n < 20);
      chk("cycles", 16'(ncyc * 4), 16'(n));
      chk("fetches", 16'(ncyc), 16'(nf));
   endtask : issue

   // ********************
   // scenarios
   // ********************
   task automatic t_move();
      poke(7'h10, 8'h3C);
      issue(mov_to_acc_op, 7'h10, 8'h00, 1);
      chk("acc mov", 16'h3C, acc);
      issue(mov_imm_op, 7'h00, 8'h5A, 1);
      chk("acc imm", 16'h5A, acc);
      issue(mov_to_mem_op, 7'h11, 8'h00, 1);
      chk("mem mov", 16'h5A, mem_at(7'h11));
      chk("pc step", 16'(pc0 + 11'h001), 16'(pc));
   endtask : t_move

   task automatic t_arith();
      poke(7'h12, 8'h01);
      issue(mov_imm_op, 7'h00, 8'hF0, 1);
      issue(add_imm_op, 7'h00, 8'h20, 1);
      chk("add acc", 16'h10, acc);
      chk("add carry", 16'h1, carry_flag);
      issue(add_op, 7'h12, 8'h00, 1);
      chk("add mem", 16'h11, acc);
      chk("no carry", 16'h0, carry_flag);
      issue(sub_imm_op, 7'h00, 8'h12, 1);
      chk("sub acc", 16'hFF, acc);
      chk("borrow", 16'h1, carry_flag);
      issue(sub_op, 7'h12, 8'h00, 1);
      chk("sub mem", 16'hFE, acc);
      chk("no borrow", 16'h0, carry_flag);
   endtask : t_arith

   task automatic t_logic();
      poke(7'h13, 8'h0F);
      poke(7'h14, 8'hFF);
      issue(mov_imm_op, 7'h00, 8'hF0, 1);
      issue(and_op, 7'h13, 8'h00, 1);
      chk("and", 16'h100, {zero_flag, acc});
      issue(or_op, 7'h13, 8'h00, 1);
      chk("or", 16'h00F, {zero_flag, acc});
      issue(xor_op, 7'h13, 8'h00, 1);
      chk("xor", 16'h100, {zero_flag, acc});
      issue(complement_to_acc_op, 7'h13, 8'h00, 1);
      chk("cpl acc", 16'h0F0, {zero_flag, acc});
      issue(complement_op, 7'h14, 8'h00, 1);
      chk("cpl mem", 16'h100, {zero_flag, mem_at(7'h14)});
   endtask : t_logic

   task automatic t_incdec();
      poke(7'h15, 8'hFF);
      issue(increment_to_accumulator_op, 7'h15, 8'h00, 1);
      chk("increment_to_accumulator_op", 16'h0FF, {acc, mem_at(7'h15)});
      issue(increment_op, 7'h15, 8'h00, 1);
      chk("inc", 16'h00, mem_at(7'h15));
      issue(decrement_op, 7'h15, 8'h00, 1);
      chk("dec", 16'hFF, mem_at(7'h15));
      issue(decrement_to_accumulator_op, 7'h15, 8'h00, 1);
      chk("decrement_to_accumulator_op", 16'hFEFF, {acc, mem_at(7'h15)});
   endtask : t_incdec

   task automatic t_rotate();
      poke(7'h16, 8'h01);
      poke(7'h17, 8'h01);
      issue(mov_imm_op, 7'h00, 8'hFF, 1);
      issue(add_imm_op, 7'h00, 8'h01, 1);
      issue(rotate_left_through_carry_op, 7'h16, 8'h00, 1);
      chk("rlc", 16'h003, {carry_flag, mem_at(7'h16)});
      issue(rotate_right_through_carry_op, 7'h16, 8'h00, 1);
      chk("rrc", 16'h101, {carry_flag, mem_at(7'h16)});
      issue(rotate_right_op, 7'h17, 8'h00, 1);
      chk("rr", 16'h180, {carry_flag, mem_at(7'h17)});
      issue(rotate_left_op, 7'h17, 8'h00, 1);
      chk("rl", 16'h101, {carry_flag, mem_at(7'h17)});
   endtask : t_rotate

   task automatic t_bits();
      poke(7'h18, 8'hA5);
      instr_bit <= 3'h1;
      issue(bit_set_op, 7'h18, 8'h00, 1);
      chk("bit set", 16'hA7, mem_at(7'h18));
      instr_bit <= 3'h7;
      issue(bit_clear_op, 7'h18, 8'h00, 1);
      chk("bit clr", 16'h27, mem_at(7'h18));
   endtask : t_bits

   task automatic t_skip();
      poke(7'h19, 8'h00);
      poke(7'h1A, 8'h04);
      issue(skip_zero_op, 7'h19, 8'h00, 2);
      chk("skip pc", 16'(pc0 + 11'h002), 16'(pc));
      chk("skip flush", 16'h1, saw_flush);
      poke(7'h19, 8'h01);
      issue(skip_zero_op, 7'h19, 8'h00, 1);
      chk("noskip pc", 16'(pc0 + 11'h001), 16'(pc));
      instr_bit <= 3'h2;
      issue(skip_bit_set_op, 7'h1A, 8'h00, 2);
      chk("bitset pc", 16'(pc0 + 11'h002), 16'(pc));
      issue(skip_bit_zero_op, 7'h1A, 8'h00, 1);
      chk("bitzero pc", 16'(pc0 + 11'h001), 16'(pc));
   endtask : t_skip

   task automatic t_branch();
      instr_target <= 11'h123;
      issue(unconditional_jump_op, 7'h00, 8'h00, 2);
      chk("jmp pc", 16'h123, pc);
      chk("jmp flush", 16'h1, saw_flush);
      instr_target <= 11'h200;
      issue(call_op, 7'h00, 8'h00, 2);
      pc1 = pc0;
      chk("call pc", 16'h200, pc);
      instr_target <= 11'h300;
      issue(unconditional_jump_op, 7'h00, 8'h00, 2);
      issue(return_op, 7'h00, 8'h00, 2);
      chk("ret pc", 16'(pc1 + 11'h001), 16'(pc));
      chk("ret irq", 16'h0, 16'(irq_enable));
      instr_target <= 11'h280;
      issue(call_op, 7'h00, 8'h00, 2);
      pc1 = pc0;
      issue(return_from_interrupt_op, 7'h00, 8'h00, 2);
      chk("return_from_interrupt_op pc", 16'(pc1 + 11'h001), 16'(pc));
      chk("return_from_interrupt_op irq", 16'h1, 16'(irq_enable));
   endtask : t_branch

   task automatic t_pcl_table();
      issue(mov_imm_op, 7'h00, 8'h40, 1);
      issue(mov_to_mem_op, PCL_ADDR, 8'h00, 2);
      chk("pcl pc", 16'({pc0[10:8], 8'h40}), 16'(pc));
      chk("pcl flush", 16'h1, saw_flush);
      instr_target <= 11'h2AB;
      issue(table_read_op, 7'h00, 8'h00, 2);
      chk("tbl addr", 16'h2AB, table_addr);
      chk("tbl data", 16'(8'hAB ^ 8'h55), 16'(table_data));
   endtask : t_pcl_table

   initial begin
      repeat (4) @(posedge ref_clk);
      #1;
      chk("pc reset", 16'(PC_RESET), 16'(pc));
      chk("acc reset", 16'(ACC_RESET), 16'(acc));
      @(posedge ref_clk);
      resetn <= 1'b1;
      t_move();
      t_arith();
      t_logic();
      t_incdec();
      t_rotate();
      t_bits();
      t_skip();
      t_branch();
      t_pcl_table();
      tally_and_finish();
   end

   initial begin
      #40000;
      fails++;
      tally_and_finish();
   end
endmodule : tb_instruction_cycle_sequencer
